/* File: rtl/adcsq_pkg.sv */
// Package with register layout, codes and timing constants of the conversion sequence control.
package adcsq_pkg;

	localparam int ADDR_W = 12;
	localparam int IDX_W = 10;

	// Register indices; the byte address is four times the index.
	localparam logic [IDX_W-1:0] IDX_CTRL_ONE = 10'h0b4;
	localparam logic [IDX_W-1:0] IDX_SEQ_CFG = 10'h0b5;

	localparam logic [1:0] TRIG_EXT_PIN = 2'h0;
	localparam logic [1:0] TRIG_FULL_SPEED = 2'h1;
	localparam logic [1:0] TRIG_TIMER = 2'h2;
	localparam logic [1:0] TRIG_MANUAL = 2'h3;

	localparam logic [1:0] RND_IDLE = 2'h0;
	localparam logic [1:0] RND_STEP = 2'h1;
	localparam int LFSR_UNROLL = 13;

	localparam logic [3:0] CH_FIRST_SE = 4'h0;
	localparam logic [3:0] CH_LAST_SE = 4'h7;
	localparam logic [3:0] CH_FIRST_DIFF = 4'h8;
	localparam logic [3:0] CH_SINGLE_MIN = 4'hc;
	localparam logic [3:0] CH_STEP = 4'h1;

	// Conversion timing in converter clocks; converter clock is the system clock divided by six.
	localparam logic [11:0] DEC_BASE_CLKS = 12'h040;
	localparam logic [11:0] SETTLE_CLKS = 12'h010;
	localparam logic [11:0] ADC_CLK_DIV = 12'h006;
	localparam logic [11:0] CNT_ONE = 12'h001;

	localparam logic [3:0] RES_64 = 4'h7;
	localparam logic [3:0] RES_128 = 4'h9;
	localparam logic [3:0] RES_256 = 4'ha;
	localparam logic [3:0] RES_512 = 4'hc;

	typedef struct packed {
		logic eoc;
		logic go;
		logic [1:0] trig;
		logic [1:0] rnd;
		logic [1:0] rsvd;
	} adcsq_ctrl_one_t;

	typedef struct packed {
		logic [1:0] ref_sel;
		logic [1:0] rate;
		logic [3:0] last_ch;
	} adcsq_seq_cfg_t;

	localparam adcsq_ctrl_one_t CTRL_ONE_RESET = '{eoc: 1'b0, go: 1'b0, trig: 2'h3,
		rnd: 2'h0, rsvd: 2'h3};
	localparam adcsq_seq_cfg_t SEQ_CFG_RESET = '{ref_sel: 2'h0, rate: 2'h1, last_ch: 4'h0};

	typedef enum logic {SEQ_IDLE, SEQ_CONV} adcsq_state_t;

	typedef struct packed {
		adcsq_state_t state;
		logic [3:0] ch;
		logic [3:0] end_ch;
		logic [1:0] ref_sel;
		logic [1:0] rate;
		logic [11:0] cnt;
	} adcsq_seq_t;

endpackage

/* File: rtl/adcsq_top.sv */
// Conversion sequence control with start select, sequence settings and random generator.
//
// Function
// - Trigger source picks full speed, timer or manual
// - Code 00 starts on external pin edge
// - Manual go starts only idle; reads until done
// - Sixteen-bit random generator under two-bit field
// - Code 01 steps generator thirteen unrolled steps
// - Generator field clears itself to 00 after
// - Reference select chooses sequence reference
// - Decimation code sets 64 to 512 clocks
// - Resolution 7, 9, 10, 12 bits by code
// - Single-ended sequence from input 0 to end
// - Differential sequence from first pair to end
// - End code 1100 up: single conversion only
// - End field updates after every conversion
// - Sequence end reads plus one; single unchanged
`timescale 1ns/1ps
`default_nettype none

module adcsq_top #(
	parameter logic [15:0] LFSR_POLY = 16'h8005, // Feedback taps of the generator.
	parameter logic [15:0] LFSR_SEED = 16'hffff // Generator state after reset.
) (
	input wire logic clk, // System clock.
	input wire logic rst_n, // Synchronous reset, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB enable.
	input wire logic pwrite, // APB write.
	input wire logic [adcsq_pkg::ADDR_W-1:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error on unmapped address.
	input wire logic timer_ch0_event, // Timer 1 channel 0 compare pulse.
	input wire logic port2_pin0, // External trigger pin.
	output logic conv_active, // Sequence running.
	output logic [3:0] conv_channel, // Input code being converted.
	output logic [1:0] conv_reference, // Reference for the running sequence.
	output logic [1:0] conv_decim_code, // Decimation code for the running sequence.
	output logic [3:0] conv_resolution, // Result bits for the running sequence.
	output logic conv_done, // One pulse per finished conversion.
	output logic [15:0] rand_value // Generator state.
);

	function automatic logic [11:0] conv_cycles(input logic [1:0] code);
		conv_cycles = 12'((adcsq_pkg::DEC_BASE_CLKS << code) + adcsq_pkg::SETTLE_CLKS)
			* adcsq_pkg::ADC_CLK_DIV;
	endfunction

	function automatic logic [3:0] resolution(input logic [1:0] code);
		case (code)
			2'h0: resolution = adcsq_pkg::RES_64;
			2'h1: resolution = adcsq_pkg::RES_128;
			2'h2: resolution = adcsq_pkg::RES_256;
			default: resolution = adcsq_pkg::RES_512;
		endcase
	endfunction

	function automatic logic [15:0] lfsr_run(input logic [15:0] s, input logic [15:0] poly);
		logic [15:0] v;
		v = s;
		for (int i = 0; i < adcsq_pkg::LFSR_UNROLL; i++) begin
			v = v[15] ? ({v[14:0], 1'b0} ^ poly) : {v[14:0], 1'b0};
		end
		lfsr_run = v;
	endfunction

	adcsq_pkg::adcsq_ctrl_one_t ctrl;
	adcsq_pkg::adcsq_ctrl_one_t next_ctrl;
	adcsq_pkg::adcsq_seq_cfg_t cfg;
	adcsq_pkg::adcsq_seq_cfg_t next_cfg;
	adcsq_pkg::adcsq_seq_t seq;
	adcsq_pkg::adcsq_seq_t next_seq;
	logic [3:0] end_wr;
	logic [3:0] next_end_wr;
	logic [15:0] lfsr;
	logic [15:0] next_lfsr;
	logic pin_prev;
	logic next_pin_prev;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic next_conv_done;
	logic next_conv_active;
	logic [3:0] next_conv_channel;
	logic [3:0] next_conv_resolution;
	logic [1:0] next_conv_reference;
	logic [1:0] next_conv_decim_code;

	logic access;
	logic wr_ok;
	logic hit_one;
	logic hit_cfg;
	logic manual_start;
	logic start;
	logic last_conv;
	logic single;
	logic conv_end;
	logic seq_end;
	logic [3:0] readback_ch;
	logic [adcsq_pkg::IDX_W-1:0] idx;
	adcsq_pkg::adcsq_ctrl_one_t wd_one;
	adcsq_pkg::adcsq_seq_cfg_t wd_cfg;

	// Address decode and write qualification, shared by every register group.
	always_comb begin
		idx = paddr[adcsq_pkg::ADDR_W-1:2];
		wd_one = pwdata[7:0];
		wd_cfg = pwdata[7:0];
		hit_one = (paddr[1:0] == 2'h0) && (idx == adcsq_pkg::IDX_CTRL_ONE);
		hit_cfg = (paddr[1:0] == 2'h0) && (idx == adcsq_pkg::IDX_SEQ_CFG);
		access = psel && penable;
		wr_ok = access && pready && pwrite && !pslverr;
		// A go write counts against the source already in force, not the one written with it.
		manual_start = wr_ok && hit_one && wd_one.go
			&& (ctrl.trig == adcsq_pkg::TRIG_MANUAL)
			&& (seq.state == adcsq_pkg::SEQ_IDLE);
	end

	// Read data is captured in the first access cycle and stands with pready in the second.
	// Unmapped or unaligned addresses answer with pslverr and read as zero.
	always_comb begin
		next_prdata = prdata;
		next_pready = access && !pready;
		next_pslverr = access && !pready && !(hit_one || hit_cfg);
		if (access && !pready) begin
			next_prdata = 32'h0000_0000;
			if (hit_one) begin
				next_prdata[7:0] = ctrl;
			end else if (hit_cfg) begin
				next_prdata[7:0] = cfg;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// The start takes the end value last written, so full-speed restarts repeat one sequence.
	always_comb begin
		next_seq = seq;
		next_pin_prev = port2_pin0;
		start = 1'b0;
		conv_end = 1'b0;
		seq_end = 1'b0;
		last_conv = (seq.ch == seq.end_ch) || (seq.end_ch >= adcsq_pkg::CH_SINGLE_MIN);
		single = end_wr >= adcsq_pkg::CH_SINGLE_MIN;
		readback_ch = seq.ch;
		if (seq.end_ch < adcsq_pkg::CH_SINGLE_MIN) begin
			readback_ch = seq.ch + adcsq_pkg::CH_STEP;
		end
		case (seq.state)
			adcsq_pkg::SEQ_IDLE: begin
				case (ctrl.trig)
					adcsq_pkg::TRIG_EXT_PIN: start = port2_pin0 && !pin_prev;
					adcsq_pkg::TRIG_FULL_SPEED: start = 1'b1;
					adcsq_pkg::TRIG_TIMER: start = timer_ch0_event;
					default: start = manual_start;
				endcase
				if (start) begin
					next_seq.state = adcsq_pkg::SEQ_CONV;
					next_seq.end_ch = end_wr;
					next_seq.ref_sel = cfg.ref_sel;
					next_seq.rate = cfg.rate;
					next_seq.cnt = conv_cycles(cfg.rate) - adcsq_pkg::CNT_ONE;
					if (single) begin
						next_seq.ch = end_wr;
					end else if (end_wr <= adcsq_pkg::CH_LAST_SE) begin
						next_seq.ch = adcsq_pkg::CH_FIRST_SE;
					end else begin
						next_seq.ch = adcsq_pkg::CH_FIRST_DIFF;
					end
				end
			end
			adcsq_pkg::SEQ_CONV: begin
				if (seq.cnt != 12'h000) begin
					next_seq.cnt = seq.cnt - adcsq_pkg::CNT_ONE;
				end else begin
					conv_end = 1'b1;
					if (last_conv) begin
						seq_end = 1'b1;
						next_seq.state = adcsq_pkg::SEQ_IDLE;
					end else begin
						next_seq.ch = seq.ch + adcsq_pkg::CH_STEP;
						next_seq.cnt = conv_cycles(seq.rate) - adcsq_pkg::CNT_ONE;
					end
				end
			end
			default: next_seq.state = adcsq_pkg::SEQ_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			seq <= '{state: adcsq_pkg::SEQ_IDLE, default: '0};
			pin_prev <= 1'b0;
		end else begin
			seq <= next_seq;
			pin_prev <= next_pin_prev;
		end
	end

	// A readback update from the sequencer wins over a software write in the same cycle.
	always_comb begin
		next_ctrl = ctrl;
		next_cfg = cfg;
		next_end_wr = end_wr;
		if (ctrl.rnd == adcsq_pkg::RND_STEP) begin
			next_ctrl.rnd = adcsq_pkg::RND_IDLE;
		end
		if (wr_ok && hit_one) begin
			next_ctrl.trig = wd_one.trig;
			next_ctrl.rnd = wd_one.rnd;
			next_ctrl.rsvd = wd_one.rsvd;
		end
		if (wr_ok && hit_cfg) begin
			next_cfg = wd_cfg;
			next_end_wr = wd_cfg.last_ch;
		end
		if (start) begin
			next_ctrl.go = manual_start;
		end
		if (conv_end) begin
			next_cfg.last_ch = readback_ch;
		end
		if (seq_end) begin
			next_ctrl.go = 1'b0;
		end
		next_ctrl.eoc = 1'b0;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl <= adcsq_pkg::CTRL_ONE_RESET;
			cfg <= adcsq_pkg::SEQ_CFG_RESET;
			end_wr <= adcsq_pkg::CH_FIRST_SE;
		end else begin
			ctrl <= next_ctrl;
			cfg <= next_cfg;
			end_wr <= next_end_wr;
		end
	end

	// One generator operation is thirteen unrolled steps, done in a single clock.
	always_comb begin
		next_lfsr = lfsr;
		if (ctrl.rnd == adcsq_pkg::RND_STEP) begin
			next_lfsr = lfsr_run(lfsr, LFSR_POLY);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lfsr <= LFSR_SEED;
			rand_value <= LFSR_SEED;
		end else begin
			lfsr <= next_lfsr;
			rand_value <= next_lfsr;
		end
	end

	// Status outputs are registered from the next sequencer state, so they move with it.
	always_comb begin
		next_conv_active = next_seq.state == adcsq_pkg::SEQ_CONV;
		next_conv_channel = next_seq.ch;
		next_conv_reference = next_seq.ref_sel;
		next_conv_decim_code = next_seq.rate;
		next_conv_resolution = resolution(next_seq.rate);
		next_conv_done = conv_end;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			conv_active <= 1'b0;
			conv_channel <= adcsq_pkg::CH_FIRST_SE;
			conv_reference <= '0;
			conv_decim_code <= '0;
			conv_resolution <= '0;
			conv_done <= 1'b0;
		end else begin
			conv_active <= next_conv_active;
			conv_channel <= next_conv_channel;
			conv_reference <= next_conv_reference;
			conv_decim_code <= next_conv_decim_code;
			conv_resolution <= next_conv_resolution;
			conv_done <= next_conv_done;
		end
	end

endmodule

`default_nettype wire

/* File: test/adcsq_assertions.sv */
// Checker of the conversion sequence control behaviour at its ports.
`timescale 1ns/1ps
`default_nettype none
module adcsq_chk (
	input wire logic clk, // Clock.
	input wire logic rst_n, // Reset.
	input wire logic psel, // Select.
	input wire logic penable, // Enable.
	input wire logic pwrite, // Write.
	input wire logic pready, // Ready.
	input wire logic pslverr, // Error.
	input wire logic conv_active, // Running.
	input wire logic [3:0] conv_channel, // Channel.
	input wire logic [1:0] conv_reference, // Reference.
	input wire logic [1:0] conv_decim_code, // Rate code.
	input wire logic [3:0] conv_resolution, // Result bits.
	input wire logic conv_done, // Done pulse.
	input wire logic [15:0] rand_value // Generator.
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [2:0] wr_hist;
	always_ff @(posedge clk) begin
		wr_hist <= {wr_hist[1:0], psel && penable && pready && pwrite};
	end
	sequence s_acc; psel && !penable ##1 psel && penable; endsequence
	sequence s_start; $rose(conv_active) && conv_decim_code == 2'h0; endsequence
	property p_rdy; s_acc |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("ready missing");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_res; conv_active |-> conv_resolution == (conv_decim_code == 2'h0 ? 4'h7 :
		conv_decim_code == 2'h1 ? 4'h9 : conv_decim_code == 2'h2 ? 4'ha : 4'hc); endproperty
	a_res: assert property (p_res) else $error("bad resolution");
	property p_hold; conv_active && $past(conv_active) && !$past(conv_done) |->
		$stable(conv_reference) && $stable(conv_decim_code); endproperty
	a_hold: assert property (p_hold) else $error("settings moved");
	property p_first; $rose(conv_active) |-> conv_channel inside {4'h0, 4'h8, [4'hc:4'hf]};
	endproperty
	a_first: assert property (p_first) else $error("bad first channel");
	property p_dur; s_start |-> ##[474:486] conv_done; endproperty
	a_dur: assert property (p_dur) else $error("bad duration");
	property p_done; conv_done |=> !conv_done; endproperty
	a_done: assert property (p_done) else $error("done too long");
	property p_rand; $changed(rand_value) |-> |wr_hist; endproperty
	a_rand: assert property (p_rand) else $error("generator moved alone");
endmodule
bind adcsq_top adcsq_chk adcsq_chk_inst (.*);
`default_nettype wire

/* File: test/adc_sequence_control_test.sv */
// Self-checking bench of the conversion sequence control.
`timescale 1ns/1ps
`default_nettype none
module adc_sequence_control_test;
	localparam logic [11:0] A1 = {adcsq_pkg::IDX_CTRL_ONE, 2'b00};
	localparam logic [11:0] A2 = {adcsq_pkg::IDX_SEQ_CFG, 2'b00};
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic timer_ch0_event = 0, port2_pin0 = 0, pready, pslverr, er, conv_active, conv_done;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [3:0] conv_channel, conv_resolution;
	logic [1:0] conv_reference, conv_decim_code;
	logic [15:0] rand_value;
	logic [3:0] rtab [4] = '{adcsq_pkg::RES_64, adcsq_pkg::RES_128, adcsq_pkg::RES_256,
		adcsq_pkg::RES_512};
	int miscompares = 0, checked = 0;
	always #2.5 clk = ~clk;
	adcsq_top adcsq_top_inst (.*);
	task chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			miscompares++;
			$display("Error at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	task conclude;
		$display("Checks %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n;
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge clk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			miscompares++;
			conclude;
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task rdc(input logic [11:0] a, input logic [7:0] e);
		xfer(0, a, 8'h00);
		chk(rd, {24'h00_0000, e});
	endtask
	task wt(input logic v);
		int n;
		n = 0;
		while (conv_active !== v && n < 20000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20000) begin
			miscompares++;
			conclude;
		end
	endtask
	task cfg(input logic [7:0] c);
		chk(conv_reference, c[7:6]);
		chk(conv_decim_code, c[5:4]);
		chk(conv_resolution, rtab[c[5:4]]);
	endtask
	function automatic logic [15:0] step13(input logic [15:0] s);
		for (int i = 0; i < adcsq_pkg::LFSR_UNROLL; i++) begin
			s = {s[14:0], 1'b0} ^ (s[15] ? 16'h8005 : 16'h0000);
		end
		return s;
	endfunction
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1;
		rdc(A1, 8'h33);
		rdc(A2, 8'h10);
		xfer(0, 12'h100, 8'h00);
		chk(er, 1'b1);
		chk(rd, 32'h0000_0000);
		xfer(1, A1, 8'h37);
		repeat (3) @(posedge clk);
		chk(rand_value, step13(16'hffff));
		rdc(A1, 8'h33);
		$display("Reset and generator test done");
		xfer(1, A2, 8'h82);
		xfer(1, A1, 8'h73);
		rdc(A1, 8'h73);
		cfg(8'h82);
		xfer(1, A2, 8'hf1);
		wt(0);
		rdc(A2, 8'hf3);
		rdc(A1, 8'h33);
		$display("Manual test done");
		xfer(1, A2, 8'h3c);
		xfer(1, A1, 8'h23);
		xfer(1, A1, 8'h63);
		rdc(A1, 8'h23);
		chk(conv_active, 1'b0);
		timer_ch0_event <= 1;
		@(posedge clk);
		timer_ch0_event <= 0;
		repeat (2) @(posedge clk);
		chk(conv_channel, 4'hc);
		cfg(8'h3c);
		wt(0);
		rdc(A2, 8'h3c);
		$display("Timer test done");
		xfer(1, A2, 8'h5a);
		xfer(1, A1, 8'h03);
		port2_pin0 <= 1;
		repeat (3) @(posedge clk);
		chk({conv_active, conv_channel}, 5'h18);
		cfg(8'h5a);
		wt(0);
		repeat (3) @(posedge clk);
		chk(conv_active, 1'b0);
		rdc(A2, 8'h5b);
		$display("Pin test done");
		xfer(1, A2, 8'he0);
		xfer(1, A1, 8'h13);
		wt(1);
		cfg(8'he0);
		wt(0);
		wt(1);
		xfer(1, A1, 8'h33);
		wt(0);
		rdc(A2, 8'he1);
		$display("Full speed test done");
		conclude;
	end
endmodule
`default_nettype wire
